// *** logic/pmi_pkg.sv ***
// Overview of operation
// - Tristate input high floats line driver outputs
// - Receive valid marks nibbles on receive data
// - Receive error flags a received coding error
// - Controller asserts transmit enable during frame nibbles
// - Controller flags bad transmit nibble; device reacts
// - Carrier sense follows medium carrier condition
// - Collision output reports collision in normal mode
// - At 10 Mbit collision output reports jabber
// - Management line shared, driven in turns serially
// - Station manager clocks every management transfer
// - Unmasked interrupt gives one 40 ns low pulse
// - Mask register 1Dh gates, status 1Eh reports
// - Five address straps sampled at reset release
// - Address zero forces interface isolate mode
package pmi_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned IRQ_PULSE_NS = 40;
  localparam int unsigned IRQ_PULSE_CYC =
    (IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Nibble clock: 32 ns period at 100 Mbit (20 ns half rounds down to 2 cycles), 400 ns at 10 Mbit
  localparam int unsigned NIB_HALF_100_NS = 20;
  localparam int unsigned NIB_HALF_10_NS = 200;
  localparam logic [5:0] NIB_HALF_100 = 6'((NIB_HALF_100_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [5:0] NIB_HALF_10 = 6'((NIB_HALF_10_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [3:0] IRQ_PULSE = 4'(IRQ_PULSE_CYC);
  // Management frame field positions (bit count from start after preamble)
  localparam logic [5:0] MD_OP_END = 6'h04;
  localparam logic [5:0] MD_PHY_END = 6'h09;
  localparam logic [5:0] MD_REG_END = 6'h0e;
  localparam logic [5:0] MD_TA_END = 6'h10;
  localparam logic [5:0] MD_DATA_END = 6'h20;
  localparam logic [5:0] MD_PREAMBLE = 6'h20;
  localparam logic [4:0] REG_IRQ_MASK = 5'h1d;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h1e;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  localparam logic [4:0] ISOLATE_ADDR = 5'h00;
  // Edges after reset release before the synced straps are valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int unsigned NUM_EVENTS = 4;
endpackage : pmi_pkg

// *** logic/pmi_if.sv ***
`timescale 1ns/1ps
interface pmi_if;
  logic rx_clk;
  logic tx_clk;
  logic rx_dv;
  logic rx_er;
  logic [3:0] rxd;
  logic tx_en;
  logic tx_er;
  logic [3:0] txd;
  logic crs;
  logic col;
  logic mdc;
  logic mdio_dev_o;
  logic mdio_dev_oe;
  logic mdio_sta_o;
  logic mdio_sta_oe;
  logic mgmt_irq_n;
  wire mdio = mdio_dev_oe ? mdio_dev_o : (mdio_sta_oe ? mdio_sta_o : 1'b1);
  modport dev (output rx_clk, tx_clk, rx_dv, rx_er, rxd, crs, col, mdio_dev_o, mdio_dev_oe,
    mgmt_irq_n, input tx_en, tx_er, txd, mdc, mdio);
  modport mac (input rx_clk, tx_clk, rx_dv, rx_er, rxd, crs, col, mgmt_irq_n, mdio,
    output tx_en, tx_er, txd, mdc, mdio_sta_o, mdio_sta_oe);
endinterface : pmi_if

// *** logic/pmi_sync.sv ***
`timescale 1ns/1ps
module pmi_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : pmi_sync

// *** logic/pmi_dev.sv ***
`timescale 1ns/1ps
module pmi_dev
  import pmi_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  pmi_if.dev link,
  input wire logic line_driver_tristate_i,
  input wire logic speed10_i,
  input wire logic [4:0] addr_strap_i,
  input wire logic rx_valid_i,
  input wire logic rx_code_err_i,
  input wire logic [3:0] rx_nibble_i,
  input wire logic carrier_i,
  input wire logic collision_i,
  input wire logic jabber_i,
  input wire logic [NUM_EVENTS-1:0] event_i,
  output logic tp_drive_en_o,
  output logic tp_tx_valid_o,
  output logic tp_tx_err_o,
  output logic [3:0] tp_tx_nibble_o,
  output logic isolate_o
);
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000, MD_HDR = 3'b001, MD_TURN = 3'b011, MD_DATA = 3'b010
  } pmi_md_state_type;

  typedef struct packed {
    logic [5:0] div;
    logic nib_clk;
    logic [4:0] addr;
    logic strapped;
    logic [1:0] strap_age;
    logic rx_dv;
    logic rx_er;
    logic [3:0] rxd;
    logic crs;
    logic col;
    logic tx_valid;
    logic tx_err;
    logic [3:0] tx_nib;
    logic drive_en;
    logic mdc_q;
    pmi_md_state_type md_state;
    logic [5:0] md_cnt;
    logic [13:0] md_hdr;
    logic [15:0] md_shift;
    logic md_oe;
    logic md_out;
    logic [15:0] irq_mask;
    logic [15:0] irq_status;
    logic [3:0] irq_cnt;
    logic irq_n;
  } pmi_dev_state_type;

  pmi_dev_state_type r, next_r;
  logic [4:0] strap_s;
  logic tri_s, mdc_s, mdio_s;
  logic tx_en_s, tx_er_s;
  logic [3:0] txd_s;
  logic rx_valid_s, rx_code_err_s, carrier_s, collision_s, jabber_s;
  logic [3:0] rx_nibble_s;

  pmi_sync #(.W(9)) u_line (.clock_i(clock_i), .resetn_i(resetn_i),
    .d_i({rx_valid_i, rx_code_err_i, rx_nibble_i, carrier_i, collision_i, jabber_i}),
    .q_o({rx_valid_s, rx_code_err_s, rx_nibble_s, carrier_s, collision_s, jabber_s}));
  pmi_sync #(.W(5)) u_strap (.clock_i(clock_i), .resetn_i(resetn_i), .d_i(addr_strap_i),
    .q_o(strap_s));
  pmi_sync #(.W(9)) u_pins (.clock_i(clock_i), .resetn_i(resetn_i),
    .d_i({line_driver_tristate_i, link.mdc, link.mdio, link.tx_en, link.tx_er, link.txd}),
    .q_o({tri_s, mdc_s, mdio_s, tx_en_s, tx_er_s, txd_s}));

  function automatic logic md_hdr_hit(input logic [13:0] h, input logic [4:0] a,
                                       input logic [4:0] rg);
    md_hdr_hit = (h[13:9] == a) && (h[4:0] == rg);
  endfunction : md_hdr_hit

  always_comb
  begin
    logic [15:0] raised;
    logic mdc_rise, mdc_fall, nib_rise;
    next_r = r;
    raised = '0;
    mdc_rise = mdc_s && !r.mdc_q;
    mdc_fall = !mdc_s && r.mdc_q;
    nib_rise = 1'b0;
    next_r.mdc_q = mdc_s;
    // Own clock divided down to the nibble rate
    if (r.div == 6'h00)
    begin
      next_r.nib_clk = !r.nib_clk;
      next_r.div = (speed10_i ? NIB_HALF_10 : NIB_HALF_100) - 6'h01;
      nib_rise = !r.nib_clk;
    end
    else
    begin
      next_r.div = r.div - 6'h01;
    end
    // Straps caught once, after the sync stages have filled past reset
    if (!r.strapped)
    begin
      if (r.strap_age == STRAP_SETTLE)
      begin
        next_r.addr = strap_s;
        next_r.strapped = 1'b1;
      end
      else
        next_r.strap_age = r.strap_age + 2'h1;
    end
    // Receive and transmit move on the nibble clock rising edge
    if (nib_rise)
    begin
      next_r.rx_dv = rx_valid_s;
      next_r.rx_er = rx_valid_s && rx_code_err_s;
      next_r.rxd = rx_valid_s ? rx_nibble_s : 4'h0;
      next_r.tx_valid = tx_en_s;
      next_r.tx_err = tx_en_s && tx_er_s;
      next_r.tx_nib = tx_er_s ? 4'h0 : txd_s;
    end
    next_r.crs = carrier_s;
    next_r.col = speed10_i ? (collision_s || jabber_s) : collision_s;
    next_r.drive_en = !tri_s;
    // Management slave: sampled on MDC rise, driven after MDC fall
    case (r.md_state)
      MD_IDLE:
      begin
        next_r.md_oe = 1'b0;
        if (mdc_rise)
        begin
          if (mdio_s)
            next_r.md_cnt = (r.md_cnt == MD_PREAMBLE) ? r.md_cnt : r.md_cnt + 6'h01;
          else if (r.md_cnt == MD_PREAMBLE)
          begin
            // Start bit one is taken here; count holds the index of the next bit
            next_r.md_state = MD_HDR;
            next_r.md_cnt = 6'h02;
            next_r.md_hdr = '0;
          end
          else
            next_r.md_cnt = 6'h00;
        end
      end
      MD_HDR:
      begin
        if (mdc_rise)
        begin
          next_r.md_hdr = {r.md_hdr[12:0], mdio_s};
          next_r.md_cnt = r.md_cnt + 6'h01;
          if (r.md_cnt == MD_REG_END)
          begin
            next_r.md_state = MD_TURN;
            next_r.md_shift = ({r.md_hdr[3:0], mdio_s} == REG_IRQ_STATUS) ? r.irq_status
                            : ({r.md_hdr[3:0], mdio_s} == REG_IRQ_MASK) ? r.irq_mask : 16'h0000;
          end
        end
      end
      MD_TURN:
      begin
        // Read: release the line for TA bit 1, drive zero for TA bit 2
        if (mdc_fall && r.md_hdr[11:10] == 2'b10 && r.md_hdr[9:5] == r.addr
            && r.md_cnt == MD_TA_END)
        begin
          next_r.md_oe = 1'b1;
          next_r.md_out = 1'b0;
        end
        if (mdc_rise)
        begin
          next_r.md_cnt = r.md_cnt + 6'h01;
          if (r.md_cnt == MD_TA_END)
            next_r.md_state = MD_DATA;
        end
      end
      MD_DATA:
      begin
        if (mdc_fall && r.md_oe)
        begin
          next_r.md_out = r.md_shift[15];
          next_r.md_shift = {r.md_shift[14:0], 1'b0};
        end
        if (mdc_rise)
        begin
          next_r.md_cnt = r.md_cnt + 6'h01;
          if (!r.md_oe)
            next_r.md_shift = {r.md_shift[14:0], mdio_s};
          if (r.md_cnt == MD_DATA_END)
          begin
            next_r.md_state = MD_IDLE;
            next_r.md_cnt = 6'h00;
            if (r.md_hdr[11:10] == 2'b01 && r.md_hdr[9:5] == r.addr
                && r.md_hdr[4:0] == REG_IRQ_MASK)
              next_r.irq_mask = {r.md_shift[14:0], mdio_s};
          end
        end
        if (mdc_fall && r.md_cnt == MD_DATA_END + 6'h01)
          next_r.md_oe = 1'b0;
      end
      default:
        next_r.md_state = MD_IDLE;
    endcase
    if (r.md_state == MD_IDLE && r.md_oe == 1'b0 && mdc_fall)
      next_r.md_oe = 1'b0;
    // Sticky interrupt status; a new event wins over the clear-on-read
    raised[NUM_EVENTS-1:0] = event_i;
    if (r.md_state == MD_TURN && next_r.md_state == MD_DATA && r.md_hdr[11:10] == 2'b10
        && md_hdr_hit({r.md_hdr[9:5], 4'h0, r.md_hdr[4:0]}, r.addr, REG_IRQ_STATUS))
      next_r.irq_status = raised;
    else
      next_r.irq_status = r.irq_status | raised;
    // One low pulse per new unmasked event
    if (|(raised & r.irq_mask))
    begin
      next_r.irq_cnt = IRQ_PULSE;
      next_r.irq_n = 1'b0;
    end
    else if (r.irq_cnt > 4'h1)
      next_r.irq_cnt = r.irq_cnt - 4'h1;
    else
    begin
      next_r.irq_cnt = 4'h0;
      next_r.irq_n = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r <= '0;
      r.irq_mask <= IRQ_MASK_RESET;
      r.irq_n <= 1'b1;
      r.drive_en <= 1'b0;
    end
    else
      r <= next_r;
  end

  // Isolate blanks receive valid and receive error toward the controller; rxd, crs and col pass through
  assign link.rx_clk = r.nib_clk;
  assign link.tx_clk = r.nib_clk;
  assign link.rx_dv = r.rx_dv && !isolate_o;
  assign link.rx_er = r.rx_er && !isolate_o;
  assign link.rxd = r.rxd;
  assign link.crs = r.crs;
  assign link.col = r.col;
  assign link.mdio_dev_o = r.md_out;
  assign link.mdio_dev_oe = r.md_oe;
  assign link.mgmt_irq_n = r.irq_n;
  assign tp_drive_en_o = r.drive_en;
  assign tp_tx_valid_o = r.tx_valid && r.drive_en;
  assign tp_tx_err_o = r.tx_err;
  assign tp_tx_nibble_o = r.tx_nib;
  assign isolate_o = r.strapped && (r.addr == ISOLATE_ADDR);
endmodule : pmi_dev

// *** logic/pmi_mac.sv ***
`timescale 1ns/1ps
module pmi_mac
  import pmi_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  pmi_if.mac link,
  input wire logic tx_valid_i,
  input wire logic tx_err_i,
  input wire logic [3:0] tx_nibble_i,
  output logic tx_taken_o,
  output logic rx_valid_o,
  output logic rx_err_o,
  output logic [3:0] rx_nibble_o,
  output logic crs_o,
  output logic col_o,
  output logic irq_o
);
  typedef struct packed {
    logic txc_q;
    logic rxc_q;
    logic tx_en;
    logic tx_er;
    logic [3:0] txd;
    logic taken;
    logic rx_valid;
    logic rx_err;
    logic [3:0] rx_nib;
    logic crs;
    logic col;
    logic irq_q;
    logic irq;
  } pmi_mac_state_type;

  pmi_mac_state_type r, next_r;
  logic txc_s, rxc_s, dv_s, er_s, crs_s, col_s, irqn_s;
  logic [3:0] rxd_s;

  pmi_sync #(.W(11)) u_in (.clock_i(clock_i), .resetn_i(resetn_i),
    .d_i({link.tx_clk, link.rx_clk, link.rx_dv, link.rx_er, link.crs, link.col,
          link.mgmt_irq_n, link.rxd}),
    .q_o({txc_s, rxc_s, dv_s, er_s, crs_s, col_s, irqn_s, rxd_s}));

  always_comb
  begin
    next_r = r;
    next_r.txc_q = txc_s;
    next_r.rxc_q = rxc_s;
    next_r.irq_q = irqn_s;
    next_r.taken = 1'b0;
    // Transmit signals change only on the device's transmit clock fall
    if (!txc_s && r.txc_q)
    begin
      next_r.tx_en = tx_valid_i;
      next_r.tx_er = tx_valid_i && tx_err_i;
      next_r.txd = tx_valid_i ? tx_nibble_i : 4'h0;
      next_r.taken = tx_valid_i;
    end
    if (rxc_s && !r.rxc_q)
    begin
      next_r.rx_valid = dv_s;
      next_r.rx_err = er_s;
      next_r.rx_nib = rxd_s;
    end
    next_r.crs = crs_s;
    next_r.col = col_s;
    next_r.irq = !irqn_s && r.irq_q;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Detector starts low: the synced pin reads low for two edges after reset
      r <= '0;
    end
    else
      r <= next_r;
  end

  // Management master lives in the bench; this end leaves its pins undriven
  assign link.tx_en = r.tx_en;
  assign link.tx_er = r.tx_er;
  assign link.txd = r.txd;
  assign tx_taken_o = r.taken;
  assign rx_valid_o = r.rx_valid;
  assign rx_err_o = r.rx_err;
  assign rx_nibble_o = r.rx_nib;
  assign crs_o = r.crs;
  assign col_o = r.col;
  assign irq_o = r.irq;
endmodule : pmi_mac

// *** verification/pmi_props.sv ***
`timescale 1ns/1ps
// ==========
// Link checker
module pmi_props (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic rx_clk,
  input wire logic tx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic crs,
  input wire logic col,
  input wire logic tx_en,
  input wire logic mgmt_irq_n,
  input wire logic speed10_i,
  input wire logic line_driver_tristate_i,
  input wire logic rx_valid_i,
  input wire logic rx_code_err_i,
  input wire logic carrier_i,
  input wire logic collision_i,
  input wire logic jabber_i,
  input wire logic tx_valid_i,
  input wire logic isolate_o,
  input wire logic tp_drive_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Five cycles of 8 ns make the 40 ns low pulse
  sequence s_irq_low;
    (!mgmt_irq_n) [*5];
  endsequence
  a_irq_pulse_width: assert property ($fell(mgmt_irq_n) |-> s_irq_low ##1 mgmt_irq_n)
    else $error("interrupt pulse has the wrong width");
  a_nib_clk_shared: assert property (rx_clk == tx_clk)
    else $error("receive and transmit clocks differ");
  a_nib_clk_half: assert property (!speed10_i && $rose(rx_clk) |-> ##[2:3] $fell(rx_clk))
    else $error("nibble clock half period wrong");
  a_isolate_no_valid: assert property (isolate_o |-> !rx_dv && !rx_er)
    else $error("receive valid while isolated");
  a_rx_valid_follow: assert property ($rose(rx_valid_i) && !isolate_o |-> ##[1:60] rx_dv)
    else $error("receive valid not raised");
  a_rx_err_follow: assert property ($rose(rx_code_err_i) && !isolate_o |-> ##[1:60] rx_er)
    else $error("receive error not raised");
  a_crs_follow: assert property ($rose(carrier_i) |-> ##[1:8] crs)
    else $error("carrier sense not raised");
  a_col_follow: assert property ($rose(collision_i) |-> ##[1:60] col)
    else $error("collision not raised");
  a_col_jabber: assert property (speed10_i && $rose(jabber_i) |-> ##[1:60] col)
    else $error("jabber not shown on collision");
  a_tristate_float: assert property ($rose(line_driver_tristate_i) |-> ##[1:4] !tp_drive_en_o)
    else $error("line driver not floated");
  a_tx_en_follow: assert property ($rose(tx_valid_i) |-> ##[1:60] tx_en)
    else $error("transmit enable not raised");
endmodule : pmi_props

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import pmi_pkg::*;
;
  logic clock_i, resetn_i, line_driver_tristate_i, speed10_i, rx_valid_i, rx_code_err_i, err;
  logic carrier_i, collision_i, jabber_i, tx_valid_i, tx_err_i, tp_drive_en_o, tp_tx_valid_o;
  logic tp_tx_err_o, isolate_o, tx_taken_o, rx_valid_o, rx_err_o, crs_o, col_o, irq_o;
  logic [3:0] rx_nibble_i, tx_nibble_i, tp_tx_nibble_o, rx_nibble_o, nib;
  logic [4:0] addr_strap_i;
  logic [NUM_EVENTS-1:0] event_i;
  logic [15:0] rd;
  int fail_count, cmp_count, irq_seen, taken_seen;

  pmi_if pmi_if_inst ();
  pmi_dev pmi_dev_inst (.clock_i, .resetn_i, .link(pmi_if_inst), .line_driver_tristate_i,
    .speed10_i, .addr_strap_i, .rx_valid_i, .rx_code_err_i, .rx_nibble_i, .carrier_i,
    .collision_i, .jabber_i, .event_i, .tp_drive_en_o, .tp_tx_valid_o, .tp_tx_err_o,
    .tp_tx_nibble_o, .isolate_o);
  pmi_mac pmi_mac_inst (.clock_i, .resetn_i, .link(pmi_if_inst), .tx_valid_i, .tx_err_i,
    .tx_nibble_i, .tx_taken_o, .rx_valid_o, .rx_err_o, .rx_nibble_o, .crs_o, .col_o, .irq_o);
  pmi_props pmi_props_inst (.clock_i, .resetn_i, .rx_clk(pmi_if_inst.rx_clk),
    .tx_clk(pmi_if_inst.tx_clk), .rx_dv(pmi_if_inst.rx_dv), .rx_er(pmi_if_inst.rx_er),
    .crs(pmi_if_inst.crs), .col(pmi_if_inst.col), .tx_en(pmi_if_inst.tx_en),
    .mgmt_irq_n(pmi_if_inst.mgmt_irq_n), .speed10_i, .line_driver_tristate_i, .rx_valid_i,
    .rx_code_err_i, .carrier_i, .collision_i, .jabber_i, .tx_valid_i, .isolate_o, .tp_drive_en_o);

  // ==========
  // Clock, watchdog and helpers
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial
  begin
    #300000;
    fail_count++;
    end_of_test();
  end
  always @(posedge clock_i)
    if (irq_o === 1'b1)
      irq_seen++;
  always @(posedge clock_i)
    if (tx_taken_o === 1'b1)
      taken_seen++;

  task step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic exp_col(input logic spd, input logic coll, input logic jab);
    return coll | (spd & jab);
  endfunction : exp_col
  function automatic logic [3:0] exp_tx_nib(input logic [3:0] n, input logic e);
    return e ? 4'h0 : n;
  endfunction : exp_tx_nib
  task rst(input logic [4:0] strap, input logic spd);
    resetn_i = 1'b0;
    addr_strap_i = strap;
    speed10_i = spd;
    step(2);
    resetn_i = 1'b1;
    step(6);
  endtask : rst
  // The bench clocks management at 80 ns; it lets go of the line from turnaround on reads
  task mdio_frame(input logic [63:0] bits, input logic rd_op, output logic [15:0] data);
    for (int i = 63; i >= 0; i--)
    begin
      pmi_if_inst.mdio_sta_oe = !(rd_op && i < 18);
      pmi_if_inst.mdio_sta_o = bits[i];
      pmi_if_inst.mdc = 1'b0;
      #40;
      data = {data[14:0], pmi_if_inst.mdio};
      pmi_if_inst.mdc = 1'b1;
      #40;
    end
    pmi_if_inst.mdio_sta_oe = 1'b0;
  endtask : mdio_frame
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // ==========
  // Tests
  initial
  begin
    void'($urandom(32'he67f));
    {line_driver_tristate_i, rx_valid_i, rx_code_err_i, carrier_i, collision_i} = '0;
    {jabber_i, tx_valid_i, tx_err_i, rx_nibble_i, tx_nibble_i, event_i} = '0;
    {resetn_i, speed10_i, addr_strap_i} = '0;
    {pmi_if_inst.mdc, pmi_if_inst.mdio_sta_o, pmi_if_inst.mdio_sta_oe} = 3'b010;
    rst(5'($urandom_range(31, 1)), 1'b0);
    check("isolate", isolate_o, 1'b0);
    check("drive enable", tp_drive_en_o, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      nib = (k == 0) ? 4'hf : 4'($urandom);
      err = (k == 0) ? 1'b1 : 1'($urandom);
      {rx_valid_i, rx_nibble_i, rx_code_err_i} = {1'b1, nib, err};
      {tx_valid_i, tx_nibble_i, tx_err_i} = {1'b1, ~nib, err};
      step(20);
      check("rx valid", rx_valid_o, 1'b1);
      check("rx nibble", rx_nibble_o, nib);
      check("rx error", rx_err_o, err);
      check("tx valid", tp_tx_valid_o, 1'b1);
      check("tx nibble", tp_tx_nibble_o, exp_tx_nib(~nib, err));
      check("tx error", tp_tx_err_o, err);
    end
    {rx_valid_i, tx_valid_i} = 2'b00;
    step(20);
    check("rx idle", rx_valid_o, 1'b0);
    check("tx idle", tp_tx_valid_o, 1'b0);
    check("tx taken", taken_seen > 0, 1'b1);
    $display("test stream done");
    tx_valid_i = 1'b1;
    line_driver_tristate_i = 1'b1;
    step(10);
    check("floated", tp_drive_en_o, 1'b0);
    check("floated tx", tp_tx_valid_o, 1'b0);
    {line_driver_tristate_i, tx_valid_i} = 2'b00;
    step(10);
    check("driving", tp_drive_en_o, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      {collision_i, carrier_i} = 2'(k);
      step(10);
      check("carrier", crs_o, carrier_i);
      check("collision", col_o, exp_col(1'b0, collision_i, 1'b0));
    end
    $display("test line status done");
    mdio_frame({32'hffffffff, 4'b0101, addr_strap_i, REG_IRQ_MASK, 2'b10, 16'h0001}, 1'b0, rd);
    step(2);
    event_i = 4'h2;
    step(1);
    event_i = 4'h0;
    step(10);
    check("masked irq", irq_seen, 0);
    event_i = 4'h1;
    step(1);
    event_i = 4'h0;
    step(10);
    check("irq pulse", irq_seen, 1);
    mdio_frame({32'hffffffff, 4'b0110, addr_strap_i, REG_IRQ_STATUS, 18'h30000}, 1'b1, rd);
    check("status set", rd[0], 1'b1);
    mdio_frame({32'hffffffff, 4'b0110, addr_strap_i, REG_IRQ_STATUS, 18'h30000}, 1'b1, rd);
    check("status cleared", rd[0], 1'b0);
    $display("test interrupt done");
    rst(5'h00, 1'b0);
    check("isolate", isolate_o, 1'b1);
    rx_valid_i = 1'b1;
    step(20);
    check("isolated rx", rx_valid_o, 1'b0);
    rx_valid_i = 1'b0;
    rst(5'($urandom_range(31, 1)), 1'b1);
    {collision_i, jabber_i} = 2'b01;
    step(120);
    check("jabber", col_o, exp_col(1'b1, 1'b0, 1'b1));
    $display("test isolate and slow rate done");
    end_of_test();
  end
endmodule : tb_top
